// file: rtl/rsb_pkg.sv
package rsb_pkg;

    // storage geometry
    localparam int unsigned DEPTH    = 55000;
    localparam int unsigned PTR_W    = 16;
    localparam int unsigned VAL_W    = 24;

    // timing: clock period and stamp resolutions in ns, their lengths and the boot wait in clock cycles
    localparam int unsigned CLK_NS   = 40;
    localparam int unsigned MS_NS    = 1000000;
    localparam int unsigned HUND_NS  = 10000000;
    localparam int unsigned MS_CYC   = MS_NS / CLK_NS;
    localparam int unsigned HUND_CYC = HUND_NS / CLK_NS;
    localparam int unsigned BOOT_CYC = 3;

    // register addresses
    localparam logic [7:0] A_CTRL   = 8'h00;
    localparam logic [7:0] A_COUNT  = 8'h04;
    localparam logic [7:0] A_CMD    = 8'h08;
    localparam logic [7:0] A_STATUS = 8'h0C;
    localparam logic [7:0] A_HELD   = 8'h10;
    localparam logic [7:0] A_NEXT   = 8'h14;
    localparam logic [7:0] A_RIDX   = 8'h18;
    localparam logic [7:0] A_RVAL   = 8'h1C;
    localparam logic [7:0] A_RSTAMP = 8'h20;
    localparam logic [7:0] A_RDATE  = 8'h24;
    localparam logic [7:0] A_PKPK   = 8'h28;
    localparam logic [7:0] A_TIME   = 8'h2C;
    localparam logic [7:0] A_DATE   = 8'h30;

    // field positions
    localparam int unsigned CTRL_AUTO  = 0;
    localparam int unsigned CTRL_RTC   = 1;
    localparam int unsigned CTRL_DELTA = 2;
    localparam int unsigned CTRL_CONT  = 3;
    localparam int unsigned CMD_ARM    = 0;
    localparam int unsigned CMD_ABORT  = 1;
    localparam int unsigned CMD_PRESET = 2;
    localparam int unsigned CMD_FACT   = 3;
    localparam int unsigned ST_ACTIVE  = 0;
    localparam int unsigned ST_LOST    = 1;
    localparam int unsigned ST_FULL    = 2;
    localparam int unsigned ST_BUFRTC  = 3;

    // reset and factory values
    localparam logic [15:0] SIZE_RST  = 16'h0064;
    localparam logic        AUTO_RST  = 1'h1;
    localparam logic [15:0] SIZE_MIN  = 16'h0002;

    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } rsb_bus_t;

    typedef struct packed {
        logic             valid;
        logic [VAL_W-1:0] value;
    } rsb_rdg_t;

    typedef struct packed {
        logic [4:0] hr;
        logic [5:0] min;
        logic [5:0] sec;
        logic [6:0] hund;
    } rsb_time_t;

    typedef struct packed {
        logic [6:0] yr;
        logic [3:0] mo;
        logic [4:0] day;
    } rsb_date_t;

    typedef struct packed {
        logic [VAL_W-1:0] value;
        logic [31:0]      stamp_a;
        logic [31:0]      stamp_b;
    } rsb_entry_t;

    typedef enum logic [2:0] {
        S_BOOT = 3'b001,
        S_IDLE = 3'b010,
        S_RUN  = 3'b100
    } rsb_state_t;

endpackage : rsb_pkg

// file: rtl/rsb_store.sv
// Local design decisions: the register offsets and the plain strobed port.
`timescale 1ns/10ps

// Summary of operation
// - auto-clear on: buffer emptied when a run is armed, before any write
// - writing count zero empties the buffer at once, in any mode
// - auto-clear off: keep readings, size forced to 55000, runs append
// - auto-clear off: stop at 55000 held; full buffer emptied at next arm
// - auto-clear off: only 55000 or zero accepted; other sizes give 55000
// - power-up: auto-clear on if buffer empty, else previous setting
// - preset leaves auto-clear alone; factory default turns it on
// - any change of auto-clear after boot empties the buffer
// - relative stamps: absolute from first reading plus delta, in ms
// - appended readings stay referenced to the first stored reading
// - after power-up the relative base restarts at zero
// - readback gives one relative stamp, absolute or delta by format bit
// - clock stamps: time of day and date, seconds in hundredths
// - stamp type change during a run empties buffer and flags loss
// - store-active output high from arm until the run ends
// - abort ends a run at once, keeping stored readings
// - stored readings survive power-off when power-valid is high at power-up
// - continuous mode wraps the write pointer to zero and overwrites
// - peak-to-peak equals largest minus smallest reading written since the last clear
module rsb_store #(
    parameter int unsigned MS_CYC   = rsb_pkg::MS_CYC,
    parameter int unsigned HUND_CYC = rsb_pkg::HUND_CYC
) (
    input  wire logic              clk_sys,
    input  wire logic              rst,
    input  wire rsb_pkg::rsb_bus_t bus,
    output logic [31:0]            rdata_r,
    input  wire rsb_pkg::rsb_rdg_t rdg,
    input  wire logic              nv_valid,
    output logic                   store_active_r
);

    localparam int unsigned PW = rsb_pkg::PTR_W;
    localparam int unsigned VW = rsb_pkg::VAL_W;
    localparam logic [PW-1:0] DEPTH_V = PW'(rsb_pkg::DEPTH);

    function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
        hit = (a == b);
    endfunction : hit

    // retained storage and bookkeeping: no reset, survives power-off
    rsb_pkg::rsb_entry_t mem [0:rsb_pkg::DEPTH-1];
    logic [PW-1:0]       held_r;
    logic [PW-1:0]       ptr_r;
    logic [PW-1:0]       size_r;
    logic                auto_r;
    logic                buf_rtc_r;
    logic [VW-1:0]       min_r;
    logic [VW-1:0]       max_r;

    // volatile state
    rsb_pkg::rsb_state_t state_r;
    rsb_pkg::rsb_state_t state_nxt;
    logic [1:0]          boot_cnt_r;
    logic                nv_s1_r;
    logic                nv_s2_r;
    logic                rtc_r;
    logic                delta_r;
    logic                cont_r;
    logic                lost_r;
    logic [31:0]         rel_ms_r;
    logic [31:0]         base_r;
    logic [31:0]         prev_r;
    logic [17:0]         ms_div_r;
    logic [17:0]         hund_div_r;
    rsb_pkg::rsb_time_t  time_r;
    rsb_pkg::rsb_date_t  date_r;
    logic [PW-1:0]       ridx_r;
    rsb_pkg::rsb_entry_t ent_r;

    // bus decode
    wire wr_ctrl   = bus.wr && hit(bus.addr, rsb_pkg::A_CTRL);
    wire wr_count  = bus.wr && hit(bus.addr, rsb_pkg::A_COUNT);
    wire wr_cmd    = bus.wr && hit(bus.addr, rsb_pkg::A_CMD);
    wire wr_status = bus.wr && hit(bus.addr, rsb_pkg::A_STATUS);
    wire wr_ridx   = bus.wr && hit(bus.addr, rsb_pkg::A_RIDX);
    wire wr_time   = bus.wr && hit(bus.addr, rsb_pkg::A_TIME);
    wire wr_date   = bus.wr && hit(bus.addr, rsb_pkg::A_DATE);

    wire is_boot = (state_r == rsb_pkg::S_BOOT);
    wire is_idle = (state_r == rsb_pkg::S_IDLE);
    wire is_run  = (state_r == rsb_pkg::S_RUN);
    wire boot_go = is_boot && (boot_cnt_r == 2'(rsb_pkg::BOOT_CYC));

    wire cmd_arm   = wr_cmd && bus.wdata[rsb_pkg::CMD_ARM];
    wire cmd_abort = wr_cmd && bus.wdata[rsb_pkg::CMD_ABORT];
    wire cmd_pre   = wr_cmd && bus.wdata[rsb_pkg::CMD_PRESET];
    wire cmd_fact  = wr_cmd && bus.wdata[rsb_pkg::CMD_FACT];

    wire [15:0] cnt_req = bus.wdata[15:0];
    wire        cnt_zero = wr_count && (bus.wdata == 32'h0000_0000);
    wire        cnt_ok = (cnt_req >= rsb_pkg::SIZE_MIN) &&
                         (cnt_req <= 16'(rsb_pkg::DEPTH)) &&
                         (bus.wdata[31:16] == 16'h0000);

    // auto-clear next value; factory default forces it on, preset ignores it
    wire auto_wr  = wr_ctrl ? bus.wdata[rsb_pkg::CTRL_AUTO] : auto_r;
    wire auto_new = cmd_fact ? 1'b1 : auto_wr;
    wire auto_chg = !is_boot && (auto_new != auto_r);

    wire rtc_new  = cmd_fact ? 1'b0 : (wr_ctrl ? bus.wdata[rsb_pkg::CTRL_RTC]
                                               : rtc_r);
    wire stamp_chg_run = is_run && (rtc_new != rtc_r);

    wire full = (held_r == size_r);
    wire arm_go = cmd_arm && is_idle;
    wire arm_clr = arm_go && (auto_new || full);

    wire clear = cnt_zero || auto_chg || stamp_chg_run || arm_clr;

    // reading write: clear in the same cycle wins and the reading is lost
    wire do_wr = rdg.valid && is_run && !clear;
    wire [PW-1:0] ptr_inc = ptr_r + PW'(1);
    wire          ptr_end = (ptr_inc == size_r);
    wire [PW-1:0] ptr_nxt = ptr_end ? '0 : ptr_inc;
    wire [PW-1:0] held_inc = full ? held_r : held_r + PW'(1);
    // a non-continuous run ends when the buffer reaches its size
    wire run_done = do_wr && !cont_r && (held_inc == size_r);
    wire first = (held_r == '0);

    // relative stamps; first stored reading is zero for both
    wire [31:0] abs_ms   = first ? 32'h0000_0000 : rel_ms_r - base_r;
    wire [31:0] delta_ms = first ? 32'h0000_0000 : rel_ms_r - prev_r;

    rsb_pkg::rsb_entry_t ent_new;
    assign ent_new.value   = rdg.value;
    assign ent_new.stamp_a = rtc_r ? {8'h00, time_r} : abs_ms;
    assign ent_new.stamp_b = rtc_r ? {16'h0000, date_r} : delta_ms;

    wire ms_tick   = (ms_div_r == 18'(MS_CYC - 1));
    wire hund_tick = (hund_div_r == 18'(HUND_CYC - 1));

    // state machine
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            rsb_pkg::S_BOOT: begin
                if (boot_go) begin
                    state_nxt = rsb_pkg::S_IDLE;
                end
            end
            rsb_pkg::S_IDLE: begin
                if (arm_go && !cmd_abort && !cmd_pre) begin
                    state_nxt = rsb_pkg::S_RUN;
                end
            end
            rsb_pkg::S_RUN: begin
                if (cmd_abort || cmd_pre || run_done) begin
                    state_nxt = rsb_pkg::S_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            state_r        <= rsb_pkg::S_BOOT;
            boot_cnt_r     <= 2'h0;
            store_active_r <= 1'b0;
        end else begin
            state_r        <= state_nxt;
            boot_cnt_r     <= is_boot ? boot_cnt_r + 2'h1 : 2'h0;
            store_active_r <= (state_nxt == rsb_pkg::S_RUN);
        end
    end

    // power-valid pin crosses in from the retention supply monitor
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            nv_s1_r <= 1'b0;
            nv_s2_r <= 1'b0;
        end else begin
            nv_s1_r <= nv_valid;
            nv_s2_r <= nv_s1_r;
        end
    end

    // retained bookkeeping; frozen while rst is high so it outlives it
    always_ff @(posedge clk_sys) begin
        if (!rst) begin
            if (boot_go) begin
                if (!nv_s2_r) begin
                    held_r <= '0;
                    ptr_r  <= '0;
                    size_r <= rsb_pkg::SIZE_RST;
                    auto_r <= rsb_pkg::AUTO_RST;
                end else if (held_r == '0) begin
                    auto_r <= 1'b1;
                end
            end else begin
                auto_r <= auto_new;
                if (clear) begin
                    held_r <= '0;
                    ptr_r  <= '0;
                end else if (do_wr) begin
                    held_r <= held_inc;
                    ptr_r  <= ptr_nxt;
                end
                if (!auto_new) begin
                    size_r <= DEPTH_V;
                end else if (cmd_fact) begin
                    size_r <= rsb_pkg::SIZE_RST;
                end else if (wr_count && cnt_ok) begin
                    size_r <= cnt_req;
                end
                if (do_wr && first) begin
                    buf_rtc_r <= rtc_r;
                end
            end
        end
    end

    // storage array and running extremes
    always_ff @(posedge clk_sys) begin
        if (do_wr) begin
            mem[ptr_r] <= ent_new;
        end
        ent_r <= mem[ridx_r];
    end

    // extremes cover every reading written since the last clear
    always_ff @(posedge clk_sys) begin
        if (do_wr) begin
            if (first || $signed(rdg.value) < $signed(min_r)) begin
                min_r <= rdg.value;
            end
            if (first || $signed(rdg.value) > $signed(max_r)) begin
                max_r <= rdg.value;
            end
        end
    end

    // control bits and loss flag; loss set wins over its clear
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            rtc_r   <= 1'b0;
            delta_r <= 1'b0;
            cont_r  <= 1'b0;
            lost_r  <= 1'b0;
            ridx_r  <= '0;
        end else begin
            rtc_r <= rtc_new;
            if (cmd_fact) begin
                delta_r <= 1'b0;
                cont_r  <= 1'b0;
            end else if (wr_ctrl) begin
                delta_r <= bus.wdata[rsb_pkg::CTRL_DELTA];
                cont_r  <= bus.wdata[rsb_pkg::CTRL_CONT];
            end
            if (stamp_chg_run) begin
                lost_r <= 1'b1;
            end else if (wr_status && bus.wdata[rsb_pkg::ST_LOST]) begin
                lost_r <= 1'b0;
            end
            if (wr_ridx) begin
                ridx_r <= bus.wdata[PW-1:0];
            end
        end
    end

    // relative time base restarts at zero on every power-up
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            ms_div_r <= 18'h0_0000;
            rel_ms_r <= 32'h0000_0000;
            base_r   <= 32'h0000_0000;
            prev_r   <= 32'h0000_0000;
        end else begin
            ms_div_r <= ms_tick ? 18'h0_0000 : ms_div_r + 18'h0_0001;
            if (ms_tick) begin
                rel_ms_r <= rel_ms_r + 32'h0000_0001;
            end
            // base is taken only when the buffer is empty, so appends keep it
            if (do_wr && first) begin
                base_r <= rel_ms_r;
            end
            if (do_wr) begin
                prev_r <= rel_ms_r;
            end
        end
    end

    // time of day; month length is not checked, software corrects the date
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            hund_div_r <= 18'h0_0000;
            time_r     <= '0;
            date_r     <= '0;
        end else begin
            hund_div_r <= hund_tick ? 18'h0_0000 : hund_div_r + 18'h0_0001;
            if (wr_time) begin
                time_r <= bus.wdata[23:0];
            end else if (hund_tick) begin
                time_r.hund <= (time_r.hund == 7'h63) ? 7'h00
                                                       : time_r.hund + 7'h01;
                if (time_r.hund == 7'h63) begin
                    time_r.sec <= (time_r.sec == 6'h3B) ? 6'h00
                                                         : time_r.sec + 6'h01;
                    if (time_r.sec == 6'h3B) begin
                        time_r.min <= (time_r.min == 6'h3B) ? 6'h00
                                                             : time_r.min + 6'h01;
                        if (time_r.min == 6'h3B) begin
                            time_r.hr <= (time_r.hr == 5'h17) ? 5'h00
                                                               : time_r.hr + 5'h01;
                        end
                    end
                end
            end
            if (wr_date) begin
                date_r <= bus.wdata[15:0];
            end else if (hund_tick && time_r == {5'h17, 6'h3B, 6'h3B, 7'h63}) begin
                date_r.day <= (date_r.day == 5'h1F) ? 5'h01 : date_r.day + 5'h01;
            end
        end
    end

    // read mux
    wire [VW:0] pkpk = {max_r[VW-1], max_r} - {min_r[VW-1], min_r};
    wire [31:0] rstamp = buf_rtc_r ? ent_r.stamp_a
                       : (delta_r ? ent_r.stamp_b : ent_r.stamp_a);
    wire [31:0] ctrl_rd = {28'h000_0000, cont_r, delta_r, rtc_r, auto_r};
    wire [31:0] stat_rd = {28'h000_0000, buf_rtc_r, full, lost_r, is_run};
    logic [31:0] rd_mux;

    always_comb begin
        unique case (bus.addr)
            rsb_pkg::A_CTRL:   rd_mux = ctrl_rd;
            rsb_pkg::A_COUNT:  rd_mux = {16'h0000, size_r};
            rsb_pkg::A_STATUS: rd_mux = stat_rd;
            rsb_pkg::A_HELD:   rd_mux = {16'h0000, held_r};
            rsb_pkg::A_NEXT:   rd_mux = {16'h0000, ptr_r};
            rsb_pkg::A_RIDX:   rd_mux = {16'h0000, ridx_r};
            rsb_pkg::A_RVAL:   rd_mux = {{(32-VW){ent_r.value[VW-1]}}, ent_r.value};
            rsb_pkg::A_RSTAMP: rd_mux = rstamp;
            rsb_pkg::A_RDATE:  rd_mux = buf_rtc_r ? ent_r.stamp_b : 32'h0000_0000;
            rsb_pkg::A_PKPK:   rd_mux = {{(31-VW){pkpk[VW]}}, pkpk};
            rsb_pkg::A_TIME:   rd_mux = {8'h00, time_r};
            rsb_pkg::A_DATE:   rd_mux = {16'h0000, date_r};
            default:           rd_mux = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            rdata_r <= 32'h0000_0000;
        end else if (bus.rd) begin
            rdata_r <= rd_mux;
        end else begin
            rdata_r <= 32'h0000_0000;
        end
    end

endmodule : rsb_store

// file: test/reading_store_buffer_tb.sv
`timescale 1ns/10ps
module reading_store_buffer_tb;
    localparam int MS = 4;
    logic              clk_sys = 1'b0;
    logic              rst = 1'b1;
    logic              nv_valid = 1'b0;
    rsb_pkg::rsb_bus_t bus = '0;
    rsb_pkg::rsb_rdg_t rdg;
    logic [31:0]       rdata_r;
    logic              store_active_r;
    int                err_count = 0;
    int                comparisons = 0;
    int                seed = 32'h97b5df62;
    int                mv[int], ma[int], md[int];
    int                m_held, m_ptr, m_size, first_t, prev_t, lo, hi;
    logic              m_run = 1'b0;
    logic [31:0]       m_ctrl, v;
    always #20 clk_sys = ~clk_sys;
    rsb_store #(.MS_CYC(MS), .HUND_CYC(10)) dut_u (
        .clk_sys(clk_sys), .rst(rst), .bus(bus), .rdata_r(rdata_r),
        .rdg(rdg), .nv_valid(nv_valid), .store_active_r(store_active_r));
    rsb_meas_model mdl_u (.clk_sys(clk_sys), .rst(rst), .rdg(rdg));
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_count++;
            $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task test_done;
        if (err_count == 0 && comparisons > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : test_done
    task wr(input logic [7:0] a, input logic [31:0] d);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk_sys);
        bus.wr <= 1'b0;
        #1;
    endtask : wr
    task rdc(input logic [7:0] a, input logic [31:0] e);
        bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge clk_sys);
        bus.rd <= 1'b0;
        #1 chk(rdata_r, e);
    endtask : rdc
    task clr;
        mv.delete();
        ma.delete();
        md.delete();
        m_held = 0;
        m_ptr = 0;
        first_t = -1;
        prev_t = -1;
    endtask : clr
    task pwr(input logic keep);
        rst <= 1'b1;
        nv_valid <= keep;
        repeat (2) @(posedge clk_sys);
        rst <= 1'b0;
        repeat (6) @(posedge clk_sys);
        #1;
        m_run = 1'b0;
        // kept readings: new ones are stamped from the power-up zero
        first_t = (keep && m_held != 0) ? 0 : -1;
        prev_t = first_t;
        m_ctrl[3:1] = 3'h0;
        if (!keep) begin
            clr();
            m_size = 100;
            m_ctrl = 32'h1;
        end else if (m_held == 0) m_ctrl[0] = 1'b1;
    endtask : pwr
    task ctl(input logic [31:0] c);
        if (c[0] != m_ctrl[0] || (c[1] != m_ctrl[1] && m_run)) clr();
        if (!c[0]) m_size = 55000;
        m_ctrl = c;
        wr(rsb_pkg::A_CTRL, c);
    endtask : ctl
    task setn(input int n);
        if (n == 0) clr();
        else if (!m_ctrl[0]) m_size = 55000;
        else if (n >= 2 && n <= 55000) m_size = n;
        wr(rsb_pkg::A_COUNT, n);
    endtask : setn
    task arm;
        if (!m_run && (m_ctrl[0] || m_held == m_size)) clr();
        m_run = 1'b1;
        wr(rsb_pkg::A_CMD, 32'h1);
    endtask : arm
    task abort;
        m_run = 1'b0;
        wr(rsb_pkg::A_CMD, 32'h2);
    endtask : abort
    task put(input int gap);
        v = $random(seed);
        mdl_u.send(v[23:0], gap);
        if (m_run) begin
            if (first_t < 0) first_t = mdl_u.last_t;
            mv[m_ptr] = $signed(v[23:0]);
            ma[m_ptr] = (mdl_u.last_t - first_t) / MS;
            md[m_ptr] = prev_t < 0 ? 0 : (mdl_u.last_t - prev_t) / MS;
            prev_t = mdl_u.last_t;
            m_ptr++;
            if (m_held < m_size) m_held++;
            if (m_ptr == m_size) begin
                m_ptr = 0;
                m_run = m_ctrl[3];
            end
        end
    endtask : put
    task ent(input int i, input bit dl);
        wr(rsb_pkg::A_RIDX, i);
        @(posedge clk_sys);
        #1;
        rdc(rsb_pkg::A_RVAL, mv[i]);
        rdc(rsb_pkg::A_RSTAMP, ma[i]);
        if (dl) begin
            wr(rsb_pkg::A_CTRL, m_ctrl | 32'h4);
            rdc(rsb_pkg::A_RSTAMP, md[i]);
            wr(rsb_pkg::A_CTRL, m_ctrl);
        end
    endtask : ent
    initial begin
        repeat (20000) @(posedge clk_sys);
        err_count++;
        test_done();
    end
    initial begin
        pwr(1'b0);
        rdc(rsb_pkg::A_CTRL, 1);
        setn(3);
        setn(1);
        rdc(rsb_pkg::A_COUNT, m_size);
        arm();
        chk(store_active_r, 1);
        for (int i = 0; i < 3; i++) put(4 * i + 1);
        #1 chk(store_active_r, m_run);
        lo = mv[0];
        hi = mv[0];
        for (int i = 0; i < 3; i++) begin
            ent(i, 1'b1);
            if (mv[i] < lo) lo = mv[i];
            if (mv[i] > hi) hi = mv[i];
        end
        rdc(rsb_pkg::A_PKPK, hi - lo);
        ctl(0);
        rdc(rsb_pkg::A_HELD, 0);
        rdc(rsb_pkg::A_COUNT, 55000);
        setn(7);
        rdc(rsb_pkg::A_COUNT, 55000);
        arm();
        put(2);
        put(3);
        abort();
        chk(store_active_r, 0);
        rdc(rsb_pkg::A_HELD, 2);
        arm();
        put(20);
        rdc(rsb_pkg::A_HELD, 3);
        ent(2, 1'b0);
        abort();
        // power cycle with retained contents
        pwr(1'b1);
        rdc(rsb_pkg::A_CTRL, 0);
        rdc(rsb_pkg::A_HELD, 3);
        ent(0, 1'b0);
        arm();
        put(1);
        ent(3, 1'b0);
        abort();
        setn(0);
        rdc(rsb_pkg::A_HELD, 0);
        pwr(1'b1);
        rdc(rsb_pkg::A_CTRL, 1);
        ctl(0);
        wr(rsb_pkg::A_CMD, 32'h4);
        rdc(rsb_pkg::A_CTRL, 0);
        wr(rsb_pkg::A_CMD, 32'h8);
        clr();
        m_ctrl = 32'h1;
        m_size = 100;
        rdc(rsb_pkg::A_CTRL, 1);
        rdc(rsb_pkg::A_COUNT, m_size);
        setn(2);
        ctl(9);
        arm();
        for (int i = 0; i < 3; i++) put(i);
        #1 chk(store_active_r, 1);
        rdc(rsb_pkg::A_HELD, 2);
        rdc(rsb_pkg::A_NEXT, 1);
        ent(0, 1'b0);
        abort();
        ctl(1);
        wr(rsb_pkg::A_DATE, 32'h1234);
        arm();
        rdc(rsb_pkg::A_HELD, 0);
        put(1);
        ctl(3);
        rdc(rsb_pkg::A_HELD, 0);
        put(1);
        wr(rsb_pkg::A_RIDX, 0);
        @(posedge clk_sys);
        #1;
        rdc(rsb_pkg::A_RDATE, 32'h1234);
        abort();
        test_done();
    end
endmodule : reading_store_buffer_tb
bind rsb_store rsb_asserts chk_u (
    .clk_sys(clk_sys), .rst(rst), .bus(bus), .rdata_r(rdata_r),
    .rdg(rdg), .nv_valid(nv_valid), .store_active_r(store_active_r));

// file: test/rsb_asserts.sv
`timescale 1ns/10ps
module rsb_asserts (
    input wire logic              clk_sys,
    input wire logic              rst,
    input wire rsb_pkg::rsb_bus_t bus,
    input wire logic [31:0]       rdata_r,
    input wire rsb_pkg::rsb_rdg_t rdg,
    input wire logic              nv_valid,
    input wire logic              store_active_r
);
    default clocking dc @(posedge clk_sys); endclocking
    default disable iff (rst);
    // up_r keeps arms issued during boot out of the antecedents
    logic [2:0] up_r;
    logic [1:0] mode_r;
    wire cmd_w  = bus.wr && bus.addr == rsb_pkg::A_CMD;
    wire ctl_w  = bus.wr && bus.addr == rsb_pkg::A_CTRL;
    wire arm_w  = cmd_w && bus.wdata[0] && up_r == 3'h7;
    wire stop_w = cmd_w && !bus.wdata[0] && |bus.wdata[2:1];
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            up_r   <= 3'h0;
            mode_r <= 2'h0;
        end else begin
            if (up_r != 3'h7) up_r <= up_r + 3'h1;
            if (ctl_w) mode_r <= {bus.wdata[3], bus.wdata[1]};
            else if (cmd_w && bus.wdata[3]) mode_r <= 2'h0;
        end
    end
    sequence zero_cnt_s;
        bus.wr && bus.addr == rsb_pkg::A_COUNT && bus.wdata == 32'h0;
    endsequence
    sequence held_rd_s;
        bus.rd && bus.addr == rsb_pkg::A_HELD;
    endsequence
    sequence type_chg_s;
        store_active_r && ctl_w && bus.wdata[1] != mode_r[0];
    endsequence
    rdata_idle_a: assert property (
        !bus.rd |=> rdata_r == 32'h0) else $error("read data without read");
    arm_starts_a: assert property (
        arm_w && !store_active_r |=> store_active_r)
        else $error("arm did not start run");
    rise_cause_a: assert property (
        $rose(store_active_r) |-> $past(arm_w))
        else $error("run started without arm");
    abort_stops_a: assert property (
        stop_w |=> !store_active_r) else $error("abort did not stop run");
    fall_cause_a: assert property (
        $fell(store_active_r) |-> $past(rdg.valid || bus.wr))
        else $error("run ended without cause");
    zero_clears_a: assert property (
        zero_cnt_s ##1 held_rd_s |=> rdata_r == 32'h0)
        else $error("count zero left readings");
    type_clears_a: assert property (
        type_chg_s ##1 held_rd_s |=> rdata_r == 32'h0)
        else $error("stamp change in run kept readings");
    cont_runs_a: assert property (
        store_active_r && mode_r[1] && rdg.valid && !bus.wr
        |=> store_active_r) else $error("continuous run ended");
endmodule : rsb_asserts

// file: test/rsb_meas_model.sv
`timescale 1ns/10ps
module rsb_meas_model (
    input  wire logic         clk_sys,
    input  wire logic         rst,
    output rsb_pkg::rsb_rdg_t rdg
);
    int cnt;
    int last_t;
    always @(posedge clk_sys or posedge rst) begin
        if (rst) cnt <= 0;
        else cnt <= cnt + 1;
    end
    initial rdg = '{valid: 1'b0, value: 24'h0};
    // readings leave on a fixed phase of four so stamp gaps are exact
    task automatic send(input logic [23:0] v, input int gap);
        repeat (gap) @(posedge clk_sys);
        #1;
        while (cnt % 4 != 0) begin
            @(posedge clk_sys);
            #1;
        end
        last_t = cnt;
        rdg <= '{valid: 1'b1, value: v};
        @(posedge clk_sys);
        // idle line shows the inverse, never a stale reading
        rdg <= '{valid: 1'b0, value: ~v};
    endtask : send
endmodule : rsb_meas_model
